// [verilog/bps_cfg.svh]
// bps_cfg.svh: offsets, field positions, reset values and counts
// assumes: included by bare name from every design file that needs it
`ifndef BPS_CFG_SVH
`define BPS_CFG_SVH

// register byte offsets, one aligned word each
`define BPS_OFS_CTL     8'hB4
`define BPS_OFS_FILL_A  8'hC0
`define BPS_OFS_FILL_B  8'hC4
`define BPS_OFS_DRAIN_A 8'hC8
`define BPS_OFS_DRAIN_B 8'hCC
`define BPS_OFS_ISTAT   8'hD0
`define BPS_OFS_IMASK   8'hD4
`define BPS_OFS_DISK    8'hD8

// interrupt status bit positions
`define BPS_IRQ_DONE_A  0
`define BPS_IRQ_DONE_B  1
`define BPS_IRQ_WRONG   2
// auto-alternate bit in disk port control
`define BPS_DISK_AUTO   3

// reset values
`define BPS_CTL_RST     8'h00
`define BPS_CNT_RST     10'h000
`define BPS_IRQ_RST     3'h0

// buffer size in bytes, and the only transfer size accepted for writes
`define BPS_BUF_BYTES   10'h200
`define BPS_HSIZE_WORD  3'h2

`endif

// [verilog/bps_pkg.sv]
// bps_pkg.sv: types shared by the buffer steering block
// assumes: offsets and counts come from bps_cfg.svh
package bps_pkg;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       flow_sense;
    logic       write_select_qualifier;
    logic       write_buffer_select;
    logic       read_buffer_select;
    logic [1:0] stall_pair;
    logic       read_select_qualifier;
    logic       enable;
  } bps_ctl_t;

  // drain port toward packet engine or disk side
  typedef struct packed {
    logic       active;
    logic       buffer_b;
    logic [8:0] addr;
  } bps_drain_t;

  typedef enum logic {BPS_IDLE, BPS_RUN} bps_dstate_t;

endpackage : bps_pkg

// [verilog/bps_drain.sv]
// bps_drain.sv: drain sequencer shared by the two ping-pong buffers, one run at a time
// assumes: start is a one-cycle pulse on hclk; ready from the consumer
`timescale 1ns/1ns
`default_nettype none
`include "bps_cfg.svh"

module bps_drain (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             start,
  input  wire logic             start_b,
  input  wire logic [9:0]       len_a,
  input  wire logic [9:0]       len_b,
  input  wire logic             ready,
  output var bps_pkg::bps_drain_t drain,
  output logic                  done_a,
  output logic                  done_b
);

  bps_pkg::bps_dstate_t state_q, state_d;
  logic [9:0] cnt_q, cnt_d;
  logic [9:0] len_q, len_d;
  logic       buf_q, buf_d;
  logic       done_a_d, done_b_d;

  wire [9:0] start_len = start_b ? len_b : len_a;
  wire       last_beat = (cnt_q + 10'h001) == len_q;

  // next state: restart on start, count bytes on ready
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    len_d    = len_q;
    buf_d    = buf_q;
    done_a_d = 1'b0;
    done_b_d = 1'b0;
    if (start) begin
      buf_d = start_b;
      cnt_d = `BPS_CNT_RST;
      len_d = start_len;
      if (start_len == `BPS_CNT_RST) begin
        state_d  = bps_pkg::BPS_IDLE;
        done_a_d = ~start_b;
        done_b_d = start_b;
      end else begin
        state_d = bps_pkg::BPS_RUN;
      end
    end else begin
      case (state_q)
        bps_pkg::BPS_RUN: begin
          if (ready) begin
            cnt_d = cnt_q + 10'h001;
            if (last_beat) begin
              state_d  = bps_pkg::BPS_IDLE;
              done_a_d = ~buf_q;
              done_b_d = buf_q;
            end
          end
        end
        default: state_d = bps_pkg::BPS_IDLE;
      endcase
    end
  end

  // state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= bps_pkg::BPS_IDLE;
      cnt_q   <= `BPS_CNT_RST;
      len_q   <= `BPS_CNT_RST;
      buf_q   <= 1'b0;
      done_a  <= 1'b0;
      done_b  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      len_q   <= len_d;
      buf_q   <= buf_d;
      done_a  <= done_a_d;
      done_b  <= done_b_d;
    end
  end

  assign drain.active   = (state_q == bps_pkg::BPS_RUN);
  assign drain.buffer_b = buf_q;
  assign drain.addr     = cnt_q[8:0];

endmodule : bps_drain
`default_nettype wire

// [verilog/bps_ep2_steer.sv]
// bps_ep2_steer.sv: bulk endpoint ping-pong buffer steering, AHB-Lite regs
// assumes: token and fill strobes come from logic on hclk; one AHB slave
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "bps_cfg.svh"

module bps_ep2_steer (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic                  irq,
  // packet engine token report
  input  wire logic             tok_valid,
  input  wire logic             tok_is_in,
  // fill side
  input  wire logic             fill_strobe,
  input  wire logic             fill_end,
  output logic                  fill_buffer_b,
  output logic      [8:0]       fill_addr,
  output logic                  flow_to_engine,
  // drain side
  input  wire logic             drain_ready,
  output var bps_pkg::bps_drain_t drain
);

  // ************************************************************
  // register state
  // ************************************************************
  logic        flow_q;
  logic        wsel_q;
  logic        rsel_q;
  logic        auto_q;
  logic [9:0]  fill_a_q;
  logic [9:0]  fill_b_q;
  logic [9:0]  dlen_a_q;
  logic [9:0]  dlen_b_q;
  logic [2:0]  istat_q;
  logic [2:0]  imask_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        wsel_d;
  logic [9:0]  fill_a_d;
  logic [9:0]  fill_b_d;
  logic [2:0]  istat_d;
  logic        done_a;
  logic        done_b;

  // ************************************************************
  // ahb address phase decode
  // ************************************************************
  wire        take     = hsel & htrans[1] & hready;
  wire        in_page  = (haddr[31:8] == 24'h000000);
  wire        word_ok  = (hsize == `BPS_HSIZE_WORD);
  wire        take_wr  = take & hwrite & in_page & word_ok;
  wire        take_rd  = take & ~hwrite;

  // data phase write strobes, one per writable register
  wire        w_ctl    = wr_pend_q & (wr_addr_q == `BPS_OFS_CTL);
  wire        w_dla    = wr_pend_q & (wr_addr_q == `BPS_OFS_DRAIN_A);
  wire        w_dlb    = wr_pend_q & (wr_addr_q == `BPS_OFS_DRAIN_B);
  wire        w_istat  = wr_pend_q & (wr_addr_q == `BPS_OFS_ISTAT);
  wire        w_imask  = wr_pend_q & (wr_addr_q == `BPS_OFS_IMASK);
  wire        w_disk   = wr_pend_q & (wr_addr_q == `BPS_OFS_DISK);

  // control write fields
  bps_pkg::bps_ctl_t wctl;
  assign wctl = hwdata[7:0];

  // ************************************************************
  // buffer select qualification
  // ************************************************************
  wire wsel_load = w_ctl & wctl.write_select_qualifier;
  wire rsel_load = w_ctl & wctl.read_select_qualifier;
  wire new_wsel  = wctl.write_buffer_select;
  wire new_rsel  = wctl.read_buffer_select;

  // end of a fill flips the buffer when auto-alternate is on and no qualified write select lands in the same cycle
  wire tog       = fill_end & auto_q & ~wsel_load;

  // fill count clears when its buffer is chosen
  wire clr_a     = (wsel_load & ~new_wsel) | (tog & wsel_q);
  wire clr_b     = (wsel_load & new_wsel) | (tog & ~wsel_q);
  wire step_a    = fill_strobe & ~wsel_q &
                   (fill_a_q != `BPS_BUF_BYTES);
  wire step_b    = fill_strobe & wsel_q &
                   (fill_b_q != `BPS_BUF_BYTES);

  // write select and fill counts next values
  always_comb begin
    wsel_d = wsel_q;
    if (wsel_load) begin
      wsel_d = new_wsel;
    end else if (tog) begin
      wsel_d = ~wsel_q;
    end
  end

  assign fill_a_d = clr_a  ? `BPS_CNT_RST :
                    step_a ? fill_a_q + 10'h001 : fill_a_q;
  assign fill_b_d = clr_b  ? `BPS_CNT_RST :
                    step_b ? fill_b_q + 10'h001 : fill_b_q;

  // ************************************************************
  // wrong token and interrupt status
  // ************************************************************
  wire wrong_out = tok_valid & flow_q & ~tok_is_in;
  wire wrong_in  = tok_valid & ~flow_q & tok_is_in;

  wire [2:0] ev_set = {wrong_out | wrong_in, done_b, done_a};
  wire [2:0] w1c    = w_istat ? hwdata[2:0] : `BPS_IRQ_RST;
  wire [2:0] sel_clr;
  assign sel_clr[`BPS_IRQ_DONE_A] = rsel_load & ~new_rsel;
  assign sel_clr[`BPS_IRQ_DONE_B] = rsel_load & new_rsel;
  assign sel_clr[`BPS_IRQ_WRONG]  = 1'b0;

  // set wins over any clear in the same cycle
  assign istat_d = (istat_q & ~(w1c | sel_clr)) | ev_set;

  // ************************************************************
  // read data mux
  // ************************************************************
  wire [7:0] ctl_rd = {flow_q, 1'b0, wsel_q, rsel_q, 4'h0};
  wire [7:0] ra     = haddr[7:0];
  wire [31:0] rd_val =
    ~in_page                     ? 32'h00000000 :
    (ra == `BPS_OFS_CTL)         ? {24'h000000, ctl_rd} :
    (ra == `BPS_OFS_FILL_A)      ? {22'h0, fill_a_q} :
    (ra == `BPS_OFS_FILL_B)      ? {22'h0, fill_b_q} :
    (ra == `BPS_OFS_DRAIN_A)     ? {22'h0, dlen_a_q} :
    (ra == `BPS_OFS_DRAIN_B)     ? {22'h0, dlen_b_q} :
    (ra == `BPS_OFS_ISTAT)       ? {29'h0, istat_q} :
    (ra == `BPS_OFS_IMASK)       ? {29'h0, imask_q} :
    (ra == `BPS_OFS_DISK)        ? {28'h0, auto_q, 3'h0} :
                                   32'h00000000;

  // ************************************************************
  // drain sequencer
  // ************************************************************
  bps_drain u_drain (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (rsel_load),
    .start_b (new_rsel),
    .len_a   (dlen_a_q),
    .len_b   (dlen_b_q),
    .ready   (drain_ready),
    .drain   (drain),
    .done_a  (done_a),
    .done_b  (done_b)
  );

  // ************************************************************
  // bus interface registers
  // ************************************************************
  // data phase tracking and read data capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= take_wr;
      wr_addr_q <= haddr[7:0];
      hreadyout <= 1'b1;                   // zero wait states
      hresp     <= 1'b0;                   // always okay
      if (take_rd) begin
        hrdata <= rd_val;
      end
    end
  end

  // ************************************************************
  // control and steering registers
  // ************************************************************
  // flow direction and buffer selects
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flow_q <= 1'b0;
      wsel_q <= 1'b0;
      rsel_q <= 1'b0;
      auto_q <= 1'b0;
    end else begin
      if (w_ctl) begin
        flow_q <= wctl.flow_sense;
      end
      wsel_q <= wsel_d;
      if (rsel_load) begin
        rsel_q <= new_rsel;
      end
      if (w_disk) begin
        auto_q <= hwdata[`BPS_DISK_AUTO];
      end
    end
  end

  // fill and drain byte counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fill_a_q <= `BPS_CNT_RST;
      fill_b_q <= `BPS_CNT_RST;
      dlen_a_q <= `BPS_CNT_RST;
      dlen_b_q <= `BPS_CNT_RST;
    end else begin
      fill_a_q <= fill_a_d;
      fill_b_q <= fill_b_d;
      if (w_dla) begin
        dlen_a_q <= hwdata[9:0];
      end
      if (w_dlb) begin
        dlen_b_q <= hwdata[9:0];
      end
    end
  end

  // ************************************************************
  // interrupt and output registers
  // ************************************************************
  // sticky status, mask and registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_q        <= `BPS_IRQ_RST;
      imask_q        <= `BPS_IRQ_RST;
      irq            <= 1'b0;
      fill_buffer_b  <= 1'b0;
      fill_addr      <= 9'h000;
      flow_to_engine <= 1'b0;
    end else begin
      istat_q <= istat_d;
      if (w_imask) begin
        imask_q <= hwdata[2:0];
      end
      irq            <= |(istat_q & imask_q);
      fill_buffer_b  <= wsel_d;
      fill_addr      <= wsel_d ? fill_b_d[8:0] : fill_a_d[8:0];
      flow_to_engine <= w_ctl ? wctl.flow_sense : flow_q;
    end
  end

endmodule : bps_ep2_steer
`default_nettype wire

// [verification/bps_ep2_properties.sv]
// bps_ep2_properties.sv: concurrent checks on the steering block's ports
// assumes: bound into every bps_ep2_steer, one clock hclk
`timescale 1ns/1ns
`default_nettype none
module bps_ep2_props (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hresp,
  input wire logic                irq,
  input wire logic                tok_valid,
  input wire logic                fill_strobe,
  input wire logic                fill_end,
  input wire logic                fill_buffer_b,
  input wire logic [8:0]          fill_addr,
  input wire logic                drain_ready,
  input wire bps_pkg::bps_drain_t drain
);
  // ****************************
  // port relations
  // ****************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // bus answer and fill counter
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay)
    else $error("slave response not okay");
  property p_fill_hold;
    !fill_strobe && !fill_end |=>
      fill_addr == $past(fill_addr) || fill_addr == 9'h000;
  endproperty
  a_fill_hold: assert property (p_fill_hold)
    else $error("fill count moved with no byte");
  property p_fill_step;
    fill_strobe ##1 fill_addr != 9'h000 |->
      fill_addr == $past(fill_addr) + 9'h001;
  endproperty
  a_fill_step: assert property (p_fill_step)
    else $error("fill count missed a byte");
  property p_fill_swap; $changed(fill_buffer_b) |-> fill_addr == 9'h000;
  endproperty
  a_fill_swap: assert property (p_fill_swap)
    else $error("new fill buffer not cleared");

  // drain sequencing
  property p_drain_start; $rose(drain.active) |-> drain.addr == 9'h000;
  endproperty
  a_drain_start: assert property (p_drain_start)
    else $error("drain did not start at byte zero");
  property p_drain_step;
    drain.active && drain_ready |=> !drain.active
      || drain.addr == $past(drain.addr) + 9'h001 || drain.addr == 9'h000;
  endproperty
  a_drain_step: assert property (p_drain_step)
    else $error("drain address did not advance");
  property p_drain_stall;
    drain.active && !drain_ready |=> drain.active
      && ($stable(drain.addr) || drain.addr == 9'h000);
  endproperty
  a_drain_stall: assert property (p_drain_stall)
    else $error("drain moved during a stall");
  property p_drain_buf;
    drain.active ##1 (drain.active && drain.addr != 9'h000) |->
      $stable(drain.buffer_b);
  endproperty
  a_drain_buf: assert property (p_drain_buf)
    else $error("drained buffer changed mid run");

  // main scenarios reached
  c_drain_end: cover property (drain.active && drain_ready ##1 !drain.active);
  c_fill_swap: cover property ($changed(fill_buffer_b));
  c_token_irq: cover property (tok_valid ##2 irq);
endmodule : bps_ep2_props

bind bps_ep2_steer bps_ep2_props u_props (
  .hclk, .hresetn, .hresp, .irq, .tok_valid, .fill_strobe, .fill_end,
  .fill_buffer_b, .fill_addr, .drain_ready, .drain
);
`default_nettype wire

// [verification/bps_far_model.sv]
// bps_far_model.sv: consumer of drained bytes, prompt or stalling
// assumes: drain port of bps_ep2_steer, same hclk and hresetn
`timescale 1ns/1ns
`default_nettype none
module bps_far_model (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                slow,
  input  wire bps_pkg::bps_drain_t drain,
  output logic                     drain_ready,
  output logic [9:0]               nbytes
);
  // ****************************
  // byte sink
  // ****************************
  logic act_q;

  // take one byte per ready cycle, stall at random when slow
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drain_ready <= 1'b0;
      act_q       <= 1'b0;
      nbytes      <= 10'h000;
    end else begin
      drain_ready <= slow ? 1'($urandom % 2) : 1'b1;
      act_q       <= drain.active;
      if (drain.active && !act_q)
        nbytes <= {9'h000, drain_ready};
      else if (drain.active && drain_ready)
        nbytes <= nbytes + 10'h001;
    end
  end
endmodule : bps_far_model
`default_nettype wire

// [verification/testbench.sv]
// testbench.sv: register, token, fill and drain checks of the steering block
// assumes: design, checker and far-side model compiled before this file
`timescale 1ns/1ns
`default_nettype none
`include "bps_cfg.svh"
module testbench;
  // ****************************
  // signals and instances
  // ****************************
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic tok_valid = 1'b0, tok_is_in = 1'b0, fill_strobe = 1'b0;
  logic fill_end = 1'b0, slow = 1'b0, rd_dp = 1'b0, bsel;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = `BPS_HSIZE_WORD;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [31:0] expq[$];
  logic [9:0]  cnt[2];
  logic [7:0]  ofs[9] = '{8'hB4, 8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'hD0,
                          8'hD4, 8'hD8, 8'hF0};
  wire logic   hready, hresp, irq, fill_buffer_b, flow_to_engine, drain_ready;
  wire logic [8:0]  fill_addr;
  wire logic [9:0]  nbytes;
  wire logic [31:0] hrdata;
  wire bps_pkg::bps_drain_t drain;
  int n_errors = 0;
  int cmp_count = 0;

  bps_ep2_steer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .irq,
    .tok_valid, .tok_is_in, .fill_strobe, .fill_end, .fill_buffer_b,
    .fill_addr, .flow_to_engine, .drain_ready, .drain);
  bps_far_model far (.hclk, .hresetn, .slow, .drain, .drain_ready, .nbytes);

  // 40 ns clock
  initial begin
    forever #20 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic fill(input int n);
    @(posedge hclk);
    fill_strobe <= 1'b1;
    repeat (n) @(posedge hclk);
    fill_strobe <= 1'b0;
    @(posedge hclk);
  endtask : fill

  task automatic end_sim;
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  // read data against the oldest noted value
  always @(posedge hclk) begin
    if (rd_dp && expq.size() > 0) chk("hrdata", expq.pop_front(), hrdata);
    rd_dp <= hsel && htrans[1] && !hwrite && hready;
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    end_sim();
  end

  // ****************************
  // scenarios
  // ****************************
  initial begin
    void'($urandom(68510));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    // selects without qualifiers are ignored
    bus(1'b1, `BPS_OFS_CTL, 32'hB0);
    rd(`BPS_OFS_CTL, 32'h80);
    #1 chk("drain_active", 32'h0, {31'h0, drain.active});
    bus(1'b1, `BPS_OFS_CTL, 32'hE0);
    rd(`BPS_OFS_CTL, 32'hA0);
    #1 chk("flow", 32'h1, {31'h0, flow_to_engine});
    // fill both buffers, select only between fills
    for (int b = 1; b >= 0; b--) begin
      cnt[b] = 10'(1 + $urandom % 30);
      bus(1'b1, `BPS_OFS_CTL, {24'h0, 2'b11, b[0], 5'h0});
      fill(int'(cnt[b]));
      #1 chk("fill_addr", {22'h0, cnt[b]}, {23'h0, fill_addr});
      chk("fill_buffer_b", 32'(b), {31'h0, fill_buffer_b});
      rd(b ? `BPS_OFS_FILL_B : `BPS_OFS_FILL_A, {22'h0, cnt[b]});
    end
    bus(1'b1, `BPS_OFS_CTL, 32'hE0);
    rd(`BPS_OFS_FILL_B, 32'h0);
    rd(`BPS_OFS_FILL_A, {22'h0, cnt[0]});
    // auto alternation flips and clears the new buffer
    bus(1'b1, `BPS_OFS_DISK, 32'h8);
    for (int k = 0; k < 2; k++) begin
      @(posedge hclk);
      fill_end <= 1'b1;
      @(posedge hclk);
      fill_end <= 1'b0;
      rd(`BPS_OFS_CTL, {24'h0, 2'b10, k[0], 5'h0});
    end
    rd(`BPS_OFS_FILL_A, 32'h0);
    // every flow and token direction, irq masked in or out
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `BPS_OFS_CTL, {24'h0, i[1], 7'h0});
      bus(1'b1, `BPS_OFS_IMASK, i[1] ? 32'h0 : 32'h4);
      @(posedge hclk);
      tok_is_in <= i[0];
      tok_valid <= 1'b1;
      @(posedge hclk);
      tok_valid <= 1'b0;
      repeat (2) @(posedge hclk);
      #1 chk("irq", 32'(i == 1), {31'h0, irq});
      chk("flow", 32'(i[1]), {31'h0, flow_to_engine});
      rd(`BPS_OFS_ISTAT, {29'h0, i[1] != i[0], 2'h0});
      bus(1'b1, `BPS_OFS_ISTAT, 32'h4);
    end
    // drain A and B in both directions, prompt then stalling
    bus(1'b1, `BPS_OFS_IMASK, 32'h3);
    for (int r = 0; r < 4; r++) begin
      bsel = r[0];
      slow <= r[1];
      cnt[bsel] = 10'(16 + $urandom % 40);
      bus(1'b1, bsel ? `BPS_OFS_DRAIN_B : `BPS_OFS_DRAIN_A, {22'h0, cnt[bsel]});
      bus(1'b1, `BPS_OFS_CTL, {24'h0, r[1], 2'b00, bsel, 4'h2});
      #1 chk("drain_buf", {31'h0, bsel}, {31'h0, drain.buffer_b});
      rd(`BPS_OFS_CTL, {24'h0, r[1], 2'b01, bsel, 4'h0});
      rd(`BPS_OFS_ISTAT, r == 0 ? 32'h0 : (bsel ? 32'h1 : 32'h2));
      for (int k = 0; k < 400 && drain.active === 1'b1; k++) @(posedge hclk);
      repeat (3) @(posedge hclk);
      #1 chk("drained", {22'h0, cnt[bsel]}, {22'h0, nbytes});
      chk("irq", 32'h1, {31'h0, irq});
      rd(`BPS_OFS_ISTAT, r == 0 ? 32'h1 : 32'h3);
    end
    end_sim();
  end
endmodule : testbench
`default_nettype wire
